// ---- verilog/pbo_pkg.sv ----
// constants for the port b/c/d alternate-function override block
// Notes on behaviour
// [RQ1] an asserted override enable replaces the port register value, else the register applies
// [RQ2] serial slave mode forces the select pin to input, ignoring its direction bit
// [RQ3] as slave the serial peripheral is active only while the select pin is low
// [RQ4] serial master mode leaves select pin direction to its own direction bit
// [RQ5] a serial pin forced to input keeps its pull-up under its output bit
// [RQ6] first-port bit 0 feeds its level to pin-change source 8
// [RQ7] master-in/slave-out pin input feeds the master data input
// [RQ8] master-out/slave-in pin input feeds the slave data input
// [RQ9] first-port bits 7..4 drive compare outputs when each compare output is enabled
// [RQ10] masked pin-change pins get their digital input forced on and feed pin-change inputs
// [RQ11] first-port bits 3..0 force input with pull-up from port bit gated by disable
// [RQ12] bit 3 slave out, bit 2 master out, bit 1 serial clock; bit 0 never
// [RQ13] second-port bits 7..0 are display segments 5..12
// [RQ14] display on: second port pull-up off, input direction, digital input off
// [RQ15] third-port bits 7..2 are display segments 15..20
// [RQ16] third-port bit 1 is external interrupt 0 or display segment 21
// [RQ17] third-port bit 0 is timer capture input or display segment 22
// [RQ18] global pull-up disable keeps every port pull-up off
// [RQ19] serial master mode forces the master-in/slave-out pin to input
// [RQ20] serial slave mode forces the master-out/slave-in pin to input
// [RQ21] serial slave mode forces the serial clock pin to input
package pbo_pkg;
  localparam int PORT_W = 8;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [17:0] SEG_RST = 18'h00000;
  // first-port pin positions
  localparam int SEL_BIT = 0;
  localparam int SCK_BIT = 1;
  localparam int MOSI_BIT = 2;
  localparam int MISO_BIT = 3;
  localparam int CMP_T0A_BIT = 4;
  localparam int CMP_T1A_BIT = 5;
  localparam int CMP_T1B_BIT = 6;
  localparam int CMP_T2A_BIT = 7;
  // pin-change source number of first-port bit 0
  localparam int PCINT_BASE = 8;
  // segment numbering
  localparam int SEG_LO = 5;
  localparam int SEG_HI = 22;
  localparam int SEG_C_LAST = 12;
  localparam int SEG_D_LAST = 22;
  localparam int EXT_IRQ_BIT = 1;
  localparam int CAPTURE_BIT = 0;
endpackage : pbo_pkg

// ---- verilog/pbo_ovr_if.sv ----
// override signal bundle for one port, driven by the top and read by the port mux
`timescale 1ns/1ps
interface pbo_ovr_if #(parameter int W = 8);
  logic [W-1:0] pullup_override_en;
  logic [W-1:0] pullup_override_val;
  logic [W-1:0] dir_override_en;
  logic [W-1:0] dir_override_val;
  logic [W-1:0] outval_override_en;
  logic [W-1:0] outval_override_val;
  logic [W-1:0] input_en_override_en;
  logic [W-1:0] input_en_override_val;
  modport src (
    output pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
    output outval_override_en, outval_override_val, input_en_override_en,
    output input_en_override_val
  );
  modport mux (
    input pullup_override_en, pullup_override_val, dir_override_en, dir_override_val,
    input outval_override_en, outval_override_val, input_en_override_en,
    input input_en_override_val
  );
endinterface : pbo_ovr_if

// ---- verilog/pbo_rst_sync.sv ----
// reset release synchroniser: asserts at once, releases after two clock edges
`timescale 1ns/1ps
module pbo_rst_sync (
  // clock and raw reset
  input wire logic clk,
  input wire logic nrst,
  // synchronised reset
  output logic rst_n
);
  logic meta_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      rst_n <= meta_r;
    end
  end
endmodule : pbo_rst_sync

// ---- verilog/pbo_port_mux.sv ----
// combinational per-pin override mux for one port
`timescale 1ns/1ps
module pbo_port_mux #(
  parameter int W = 8
) (
  // overrides from the peripherals
  pbo_ovr_if.mux ov,
  // port registers and pad level
  input wire logic [W-1:0] out_reg,
  input wire logic [W-1:0] dir_reg,
  input wire logic [W-1:0] pad_in,
  input wire logic global_pullup_off,
  // resolved pad controls and gated input level
  output logic [W-1:0] pad_o,
  output logic [W-1:0] pad_oe,
  output logic [W-1:0] pad_pullup,
  output logic [W-1:0] din
);
  for (genvar i = 0; i < W; i++) begin : g_pin
    logic reg_pull;
    logic die;
    // pull-up only for an input with its output bit set, and never under global disable
    assign reg_pull = ~dir_reg[i] & out_reg[i] & ~global_pullup_off; // [RQ18]
    assign pad_pullup[i] = ov.pullup_override_en[i] ? ov.pullup_override_val[i] : reg_pull; // [RQ1]
    assign pad_oe[i] = ov.dir_override_en[i] ? ov.dir_override_val[i] : dir_reg[i]; // [RQ1]
    assign pad_o[i] = ov.outval_override_en[i] ? ov.outval_override_val[i] : out_reg[i]; // [RQ1]
    // the digital input is enabled unless a peripheral says otherwise
    assign die = ov.input_en_override_en[i] ? ov.input_en_override_val[i] : 1'b1; // [RQ1]
    assign din[i] = pad_in[i] & die;
  end
endmodule : pbo_port_mux

// ---- verilog/pbo_top.sv ----
// alternate-function override logic for the first, second and third ports
`timescale 1ns/1ps
module pbo_top #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // first port registers and pads
  input wire logic [W-1:0] out_reg_b,
  input wire logic [W-1:0] dir_reg_b,
  input wire logic [W-1:0] pad_b_in,
  output logic [W-1:0] pad_b_o,
  output logic [W-1:0] pad_b_oe,
  output logic [W-1:0] pad_b_pullup,
  output logic [W-1:0] pin_lvl_b,
  // second port registers and pads
  input wire logic [W-1:0] out_reg_c,
  input wire logic [W-1:0] dir_reg_c,
  input wire logic [W-1:0] pad_c_in,
  output logic [W-1:0] pad_c_o,
  output logic [W-1:0] pad_c_oe,
  output logic [W-1:0] pad_c_pullup,
  output logic [W-1:0] pin_lvl_c,
  // third port registers and pads
  input wire logic [W-1:0] out_reg_d,
  input wire logic [W-1:0] dir_reg_d,
  input wire logic [W-1:0] pad_d_in,
  output logic [W-1:0] pad_d_o,
  output logic [W-1:0] pad_d_oe,
  output logic [W-1:0] pad_d_pullup,
  output logic [W-1:0] pin_lvl_d,
  // global and mode controls
  input wire logic global_pullup_off,
  input wire logic serial_periph_on,
  input wire logic master_select,
  input wire logic display_ctrl_on,
  input wire logic ext_irq_zero_en,
  // pin-change controls and sources (bit i is source 8+i)
  input wire logic pin_change_group1_en,
  input wire logic [W-1:0] pin_change_mask1,
  output logic [W-1:0] pin_change_src,
  // compare unit outputs
  input wire logic cmp_out_t0_a,
  input wire logic cmp_out_t0_a_en,
  input wire logic cmp_out_t1_a,
  input wire logic cmp_out_t1_a_en,
  input wire logic cmp_out_t1_b,
  input wire logic cmp_out_t1_b_en,
  input wire logic cmp_out_t2_a,
  input wire logic cmp_out_t2_a_en,
  // serial peripheral data paths
  input wire logic spi_slave_dout,
  input wire logic spi_master_dout,
  input wire logic spi_sck_out,
  output logic spi_master_din,
  output logic spi_slave_din,
  output logic spi_sck_in,
  output logic spi_slave_active,
  // third port peripheral inputs
  output logic ext_irq_zero,
  output logic capture_in_t1,
  // display segment connections, indexed by segment number
  output logic [pbo_pkg::SEG_HI:pbo_pkg::SEG_LO] seg_link
);
  logic rst_n;
  logic spi_master;
  logic spi_slave;
  logic [W-1:0] b_o, b_oe, b_pu, b_din;
  logic [W-1:0] c_o, c_oe, c_pu, c_din;
  logic [W-1:0] d_o, d_oe, d_pu, d_din;
  logic [W-1:0] d_seg;
  logic [W-1:0] pad_b_o_r, pad_b_oe_r, pad_b_pullup_r, pin_lvl_b_r;
  logic [W-1:0] pad_c_o_r, pad_c_oe_r, pad_c_pullup_r, pin_lvl_c_r;
  logic [W-1:0] pad_d_o_r, pad_d_oe_r, pad_d_pullup_r, pin_lvl_d_r;
  logic [W-1:0] pin_change_src_r;
  logic spi_master_din_r, spi_slave_din_r, spi_sck_in_r, spi_slave_active_r;
  logic ext_irq_zero_r, capture_in_t1_r;
  logic [pbo_pkg::SEG_HI:pbo_pkg::SEG_LO] seg_link_r;
  logic [W-1:0] pad_b_o_nxt, pad_b_oe_nxt, pad_b_pullup_nxt, pin_lvl_b_nxt;
  logic [W-1:0] pad_c_o_nxt, pad_c_oe_nxt, pad_c_pullup_nxt, pin_lvl_c_nxt;
  logic [W-1:0] pad_d_o_nxt, pad_d_oe_nxt, pad_d_pullup_nxt, pin_lvl_d_nxt;
  logic [W-1:0] pin_change_src_nxt;
  logic spi_master_din_nxt, spi_slave_din_nxt, spi_sck_in_nxt, spi_slave_active_nxt;
  logic ext_irq_zero_nxt, capture_in_t1_nxt;
  logic [pbo_pkg::SEG_HI:pbo_pkg::SEG_LO] seg_link_nxt;

  pbo_ovr_if #(.W(W)) ovr_b ();
  pbo_ovr_if #(.W(W)) ovr_c ();
  pbo_ovr_if #(.W(W)) ovr_d ();

  pbo_rst_sync u_rst (
    .clk(clk),
    .nrst(nrst),
    .rst_n(rst_n)
  );

  assign spi_master = serial_periph_on & master_select;
  assign spi_slave = serial_periph_on & ~master_select;

  // first port: serial pins on 3..0, compare outputs on 7..4
  always_comb begin
    ovr_b.pullup_override_en = '0;
    ovr_b.pullup_override_val = '0;
    ovr_b.dir_override_en = '0;
    ovr_b.dir_override_val = '0;
    ovr_b.outval_override_en = '0;
    ovr_b.outval_override_val = '0;
    // the forcing term per serial pin: miso as master, the others as slave
    ovr_b.dir_override_en[pbo_pkg::MISO_BIT] = spi_master; // [RQ19] [RQ11]
    ovr_b.dir_override_en[pbo_pkg::MOSI_BIT] = spi_slave; // [RQ20] [RQ11]
    ovr_b.dir_override_en[pbo_pkg::SCK_BIT] = spi_slave; // [RQ21] [RQ11]
    ovr_b.dir_override_en[pbo_pkg::SEL_BIT] = spi_slave; // [RQ2] [RQ4] [RQ11]
    for (int i = 0; i <= pbo_pkg::MISO_BIT; i++) begin
      // a forced input still takes its pull-up from the port output bit
      ovr_b.pullup_override_en[i] = ovr_b.dir_override_en[i]; // [RQ5] [RQ11]
      ovr_b.pullup_override_val[i] = out_reg_b[i] & ~global_pullup_off; // [RQ5] [RQ18]
    end
    ovr_b.outval_override_en[pbo_pkg::MISO_BIT] = spi_slave; // [RQ12]
    ovr_b.outval_override_val[pbo_pkg::MISO_BIT] = spi_slave_dout; // [RQ12]
    ovr_b.outval_override_en[pbo_pkg::MOSI_BIT] = spi_master; // [RQ12]
    ovr_b.outval_override_val[pbo_pkg::MOSI_BIT] = spi_master_dout; // [RQ12]
    ovr_b.outval_override_en[pbo_pkg::SCK_BIT] = spi_master; // [RQ12]
    ovr_b.outval_override_val[pbo_pkg::SCK_BIT] = spi_sck_out; // [RQ12]
    // pull-up and direction on the compare pins stay with the registers
    ovr_b.outval_override_en[pbo_pkg::CMP_T0A_BIT] = cmp_out_t0_a_en; // [RQ9]
    ovr_b.outval_override_val[pbo_pkg::CMP_T0A_BIT] = cmp_out_t0_a; // [RQ9]
    ovr_b.outval_override_en[pbo_pkg::CMP_T1A_BIT] = cmp_out_t1_a_en; // [RQ9]
    ovr_b.outval_override_val[pbo_pkg::CMP_T1A_BIT] = cmp_out_t1_a; // [RQ9]
    ovr_b.outval_override_en[pbo_pkg::CMP_T1B_BIT] = cmp_out_t1_b_en; // [RQ9]
    ovr_b.outval_override_val[pbo_pkg::CMP_T1B_BIT] = cmp_out_t1_b; // [RQ9]
    ovr_b.outval_override_en[pbo_pkg::CMP_T2A_BIT] = cmp_out_t2_a_en; // [RQ9]
    ovr_b.outval_override_val[pbo_pkg::CMP_T2A_BIT] = cmp_out_t2_a; // [RQ9]
    ovr_b.input_en_override_en = pin_change_mask1 & {W{pin_change_group1_en}}; // [RQ10]
    ovr_b.input_en_override_val = '1; // [RQ10]
  end

  // second port: all pins become segment pads while the display runs
  always_comb begin
    ovr_c.pullup_override_en = {W{display_ctrl_on}}; // [RQ14]
    ovr_c.pullup_override_val = '0;
    ovr_c.dir_override_en = {W{display_ctrl_on}}; // [RQ14]
    ovr_c.dir_override_val = '0;
    ovr_c.outval_override_en = '0;
    ovr_c.outval_override_val = '0;
    ovr_c.input_en_override_en = {W{display_ctrl_on}}; // [RQ14]
    ovr_c.input_en_override_val = '0;
  end

  // third port: segment pads, except where a pin serves its interrupt role
  always_comb begin
    d_seg = {W{display_ctrl_on}}; // [RQ15] [RQ17]
    d_seg[pbo_pkg::EXT_IRQ_BIT] = display_ctrl_on & ~ext_irq_zero_en; // [RQ16]
    ovr_d.pullup_override_en = d_seg;
    ovr_d.pullup_override_val = '0;
    ovr_d.dir_override_en = d_seg;
    ovr_d.dir_override_val = '0;
    ovr_d.outval_override_en = '0;
    ovr_d.outval_override_val = '0;
    // an enabled interrupt keeps its input alive even on a display pin
    ovr_d.input_en_override_en = d_seg;
    ovr_d.input_en_override_en[pbo_pkg::EXT_IRQ_BIT] = display_ctrl_on | ext_irq_zero_en; // [RQ16]
    ovr_d.input_en_override_val = '0;
    ovr_d.input_en_override_val[pbo_pkg::EXT_IRQ_BIT] = ext_irq_zero_en; // [RQ16]
  end

  pbo_port_mux #(.W(W)) u_mux_b (
    .ov(ovr_b.mux),
    .out_reg(out_reg_b),
    .dir_reg(dir_reg_b),
    .pad_in(pad_b_in),
    .global_pullup_off(global_pullup_off),
    .pad_o(b_o),
    .pad_oe(b_oe),
    .pad_pullup(b_pu),
    .din(b_din)
  );

  pbo_port_mux #(.W(W)) u_mux_c (
    .ov(ovr_c.mux),
    .out_reg(out_reg_c),
    .dir_reg(dir_reg_c),
    .pad_in(pad_c_in),
    .global_pullup_off(global_pullup_off),
    .pad_o(c_o),
    .pad_oe(c_oe),
    .pad_pullup(c_pu),
    .din(c_din)
  );

  pbo_port_mux #(.W(W)) u_mux_d (
    .ov(ovr_d.mux),
    .out_reg(out_reg_d),
    .dir_reg(dir_reg_d),
    .pad_in(pad_d_in),
    .global_pullup_off(global_pullup_off),
    .pad_o(d_o),
    .pad_oe(d_oe),
    .pad_pullup(d_pu),
    .din(d_din)
  );

  // next values of every registered output
  always_comb begin
    pad_b_o_nxt = b_o;
    pad_b_oe_nxt = b_oe;
    pad_b_pullup_nxt = b_pu;
    pin_lvl_b_nxt = b_din;
    pad_c_o_nxt = c_o;
    pad_c_oe_nxt = c_oe;
    pad_c_pullup_nxt = c_pu;
    pin_lvl_c_nxt = c_din;
    pad_d_o_nxt = d_o;
    pad_d_oe_nxt = d_oe;
    pad_d_pullup_nxt = d_pu;
    pin_lvl_d_nxt = d_din;
    pin_change_src_nxt = b_din; // [RQ6] [RQ10]
    spi_master_din_nxt = b_din[pbo_pkg::MISO_BIT]; // [RQ7]
    spi_slave_din_nxt = b_din[pbo_pkg::MOSI_BIT]; // [RQ8]
    spi_sck_in_nxt = b_din[pbo_pkg::SCK_BIT];
    // the select pin is read straight from the pad so a masked input cannot hide it
    spi_slave_active_nxt = spi_slave & ~pad_b_in[pbo_pkg::SEL_BIT]; // [RQ3]
    ext_irq_zero_nxt = d_din[pbo_pkg::EXT_IRQ_BIT]; // [RQ16]
    capture_in_t1_nxt = pad_d_in[pbo_pkg::CAPTURE_BIT]; // [RQ17]
    seg_link_nxt = pbo_pkg::SEG_RST;
    for (int i = 0; i < W; i++) begin
      seg_link_nxt[pbo_pkg::SEG_C_LAST - i] = display_ctrl_on; // [RQ13]
      seg_link_nxt[pbo_pkg::SEG_D_LAST - i] = d_seg[i]; // [RQ15] [RQ16] [RQ17]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_b_o_r <= pbo_pkg::PORT_RST;
      pad_b_oe_r <= pbo_pkg::PORT_RST;
      pad_b_pullup_r <= pbo_pkg::PORT_RST;
      pin_lvl_b_r <= pbo_pkg::PORT_RST;
      pad_c_o_r <= pbo_pkg::PORT_RST;
      pad_c_oe_r <= pbo_pkg::PORT_RST;
      pad_c_pullup_r <= pbo_pkg::PORT_RST;
      pin_lvl_c_r <= pbo_pkg::PORT_RST;
      pad_d_o_r <= pbo_pkg::PORT_RST;
      pad_d_oe_r <= pbo_pkg::PORT_RST;
      pad_d_pullup_r <= pbo_pkg::PORT_RST;
      pin_lvl_d_r <= pbo_pkg::PORT_RST;
      pin_change_src_r <= pbo_pkg::PORT_RST;
      spi_master_din_r <= 1'b0;
      spi_slave_din_r <= 1'b0;
      spi_sck_in_r <= 1'b0;
      spi_slave_active_r <= 1'b0;
      ext_irq_zero_r <= 1'b0;
      capture_in_t1_r <= 1'b0;
      seg_link_r <= pbo_pkg::SEG_RST;
    end else begin
      pad_b_o_r <= pad_b_o_nxt;
      pad_b_oe_r <= pad_b_oe_nxt;
      pad_b_pullup_r <= pad_b_pullup_nxt;
      pin_lvl_b_r <= pin_lvl_b_nxt;
      pad_c_o_r <= pad_c_o_nxt;
      pad_c_oe_r <= pad_c_oe_nxt;
      pad_c_pullup_r <= pad_c_pullup_nxt;
      pin_lvl_c_r <= pin_lvl_c_nxt;
      pad_d_o_r <= pad_d_o_nxt;
      pad_d_oe_r <= pad_d_oe_nxt;
      pad_d_pullup_r <= pad_d_pullup_nxt;
      pin_lvl_d_r <= pin_lvl_d_nxt;
      pin_change_src_r <= pin_change_src_nxt;
      spi_master_din_r <= spi_master_din_nxt;
      spi_slave_din_r <= spi_slave_din_nxt;
      spi_sck_in_r <= spi_sck_in_nxt;
      spi_slave_active_r <= spi_slave_active_nxt;
      ext_irq_zero_r <= ext_irq_zero_nxt;
      capture_in_t1_r <= capture_in_t1_nxt;
      seg_link_r <= seg_link_nxt;
    end
  end

  assign pad_b_o = pad_b_o_r;
  assign pad_b_oe = pad_b_oe_r;
  assign pad_b_pullup = pad_b_pullup_r;
  assign pin_lvl_b = pin_lvl_b_r;
  assign pad_c_o = pad_c_o_r;
  assign pad_c_oe = pad_c_oe_r;
  assign pad_c_pullup = pad_c_pullup_r;
  assign pin_lvl_c = pin_lvl_c_r;
  assign pad_d_o = pad_d_o_r;
  assign pad_d_oe = pad_d_oe_r;
  assign pad_d_pullup = pad_d_pullup_r;
  assign pin_lvl_d = pin_lvl_d_r;
  assign pin_change_src = pin_change_src_r;
  assign spi_master_din = spi_master_din_r;
  assign spi_slave_din = spi_slave_din_r;
  assign spi_sck_in = spi_sck_in_r;
  assign spi_slave_active = spi_slave_active_r;
  assign ext_irq_zero = ext_irq_zero_r;
  assign capture_in_t1 = capture_in_t1_r;
  assign seg_link = seg_link_r;

  // checks: each output one edge after its cause
  a_sel_slave_input: assert property (@(posedge clk) disable iff (!rst_n) // [RQ2]
    spi_slave |=> !pad_b_oe_r[pbo_pkg::SEL_BIT])
    else $error("select pin drives while slave");
  a_sel_master_dir: assert property (@(posedge clk) disable iff (!rst_n) // [RQ4]
    spi_master |=> pad_b_oe_r[pbo_pkg::SEL_BIT] == $past(dir_reg_b[pbo_pkg::SEL_BIT]))
    else $error("select pin direction overridden as master");
  a_miso_master_in: assert property (@(posedge clk) disable iff (!rst_n) // [RQ19]
    spi_master |=> !pad_b_oe_r[pbo_pkg::MISO_BIT])
    else $error("miso pin drives while master");
  a_mosi_sck_slave: assert property (@(posedge clk) disable iff (!rst_n) // [RQ20]
    spi_slave |=> !pad_b_oe_r[pbo_pkg::MOSI_BIT] && !pad_b_oe_r[pbo_pkg::SCK_BIT])
    else $error("mosi or clock pin drives while slave");
  a_forced_pullup: assert property (@(posedge clk) disable iff (!rst_n) // [RQ5]
    spi_slave |=> pad_b_pullup_r[pbo_pkg::SEL_BIT] ==
      $past(out_reg_b[pbo_pkg::SEL_BIT] & ~global_pullup_off))
    else $error("forced input lost its pull-up control");
  a_pullup_disable: assert property (@(posedge clk) disable iff (!rst_n) // [RQ18]
    global_pullup_off |=> pad_b_pullup_r == '0 && pad_c_pullup_r == '0 && pad_d_pullup_r == '0)
    else $error("pull-up on under global disable");
  a_cmp_drive: assert property (@(posedge clk) disable iff (!rst_n) // [RQ9]
    (cmp_out_t2_a_en || cmp_out_t1_b_en) |=>
      (!$past(cmp_out_t2_a_en) || pad_b_o_r[pbo_pkg::CMP_T2A_BIT] == $past(cmp_out_t2_a)) &&
      (!$past(cmp_out_t1_b_en) || pad_b_o_r[pbo_pkg::CMP_T1B_BIT] == $past(cmp_out_t1_b)))
    else $error("compare output not on its pin");
  a_spi_master_out: assert property (@(posedge clk) disable iff (!rst_n) // [RQ12]
    spi_master |=> pad_b_o_r[pbo_pkg::MOSI_BIT] == $past(spi_master_dout) &&
      pad_b_o_r[pbo_pkg::SCK_BIT] == $past(spi_sck_out) &&
      pad_b_o_r[pbo_pkg::SEL_BIT] == $past(out_reg_b[pbo_pkg::SEL_BIT]))
    else $error("master output pins wrong");
  a_pc_source8: assert property (@(posedge clk) disable iff (!rst_n) // [RQ6]
    pin_change_group1_en && pin_change_mask1[0] |=> pin_change_src_r[0] == $past(pad_b_in[0]))
    else $error("pin-change source 8 does not follow its pin");
  a_slave_active: assert property (@(posedge clk) disable iff (!rst_n) // [RQ3]
    $rose(spi_slave_active_r) |-> $past(spi_slave) && !$past(pad_b_in[pbo_pkg::SEL_BIT]))
    else $error("slave active without low select");
  a_display_c: assert property (@(posedge clk) disable iff (!rst_n) // [RQ14]
    display_ctrl_on |=> pad_c_oe_r == '0 && pad_c_pullup_r == '0 && pin_lvl_c_r == '0 &&
      seg_link_r[pbo_pkg::SEG_LO] && seg_link_r[pbo_pkg::SEG_C_LAST])
    else $error("second port not released to display");
  a_slave_miso_out: assert property (@(posedge clk) disable iff (!rst_n) // [RQ12]
    spi_slave |=> pad_b_o_r[pbo_pkg::MISO_BIT] == $past(spi_slave_dout))
    else $error("slave data not on its pin");
  // the interrupt input must survive the display taking the rest of the port
  a_irq_input_kept: assert property (@(posedge clk) disable iff (!rst_n) // [RQ16]
    ext_irq_zero_en |=> !seg_link_r[pbo_pkg::SEG_D_LAST - pbo_pkg::EXT_IRQ_BIT] &&
      ext_irq_zero_r == $past(pad_d_in[pbo_pkg::EXT_IRQ_BIT]))
    else $error("interrupt pin lost to the display");
endmodule : pbo_top

// ---- tb/pbo_pad_model.sv ----
// outside circuitry on one port: drivers, pull-ups and floating pads
`timescale 1ns/1ps
module pbo_pad_model (
  // clock
  input wire logic clk,
  // device pad controls
  input wire logic [7:0] pad_o,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  // outside drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_drv,
  // resolved pad level
  output logic [7:0] pad_in
);
  // a floating pad toggles so a stale value can never look valid
  logic [7:0] float_r = 8'h55;
  always_ff @(posedge clk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_o[i];
      end else if (ext_drv[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pullup[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = float_r[i];
      end
    end
  end
endmodule : pbo_pad_model

// ---- tb/tb_pbo_top.sv ----
// self-checking bench for the port override block
`timescale 1ns/1ps
module tb_pbo_top;
  logic clk, nrst, global_pullup_off, serial_periph_on, master_select, display_ctrl_on;
  logic ext_irq_zero_en, pin_change_group1_en, spi_slave_dout, spi_master_dout, spi_sck_out;
  logic cmp_out_t0_a, cmp_out_t0_a_en, cmp_out_t1_a, cmp_out_t1_a_en;
  logic cmp_out_t1_b, cmp_out_t1_b_en, cmp_out_t2_a, cmp_out_t2_a_en;
  logic [7:0] out_reg_b, dir_reg_b, pad_b_in, pad_b_o, pad_b_oe, pad_b_pullup, pin_lvl_b;
  logic [7:0] out_reg_c, dir_reg_c, pad_c_in, pad_c_o, pad_c_oe, pad_c_pullup, pin_lvl_c;
  logic [7:0] out_reg_d, dir_reg_d, pad_d_in, pad_d_o, pad_d_oe, pad_d_pullup, pin_lvl_d;
  logic [7:0] pin_change_mask1, pin_change_src, xv_b, xd_b, xv_c, xd_c, xv_d, xd_d;
  logic spi_master_din, spi_slave_din, spi_sck_in, spi_slave_active, ext_irq_zero, capture_in_t1;
  logic [pbo_pkg::SEG_HI:pbo_pkg::SEG_LO] seg_link;
  logic [3:0] cmp, cmp_en;
  int n_mismatch = 0;
  int n_compared = 0;
  assign {cmp_out_t2_a, cmp_out_t1_b, cmp_out_t1_a, cmp_out_t0_a} = cmp;
  assign {cmp_out_t2_a_en, cmp_out_t1_b_en, cmp_out_t1_a_en, cmp_out_t0_a_en} = cmp_en;
  pbo_top #(.W(8)) pbo_top_inst (.clk, .nrst, .out_reg_b, .dir_reg_b, .pad_b_in, .pad_b_o,
    .pad_b_oe, .pad_b_pullup, .pin_lvl_b, .out_reg_c, .dir_reg_c, .pad_c_in, .pad_c_o,
    .pad_c_oe, .pad_c_pullup, .pin_lvl_c, .out_reg_d, .dir_reg_d, .pad_d_in, .pad_d_o,
    .pad_d_oe, .pad_d_pullup, .pin_lvl_d, .global_pullup_off, .serial_periph_on,
    .master_select, .display_ctrl_on, .ext_irq_zero_en, .pin_change_group1_en,
    .pin_change_mask1, .pin_change_src, .cmp_out_t0_a, .cmp_out_t0_a_en, .cmp_out_t1_a,
    .cmp_out_t1_a_en, .cmp_out_t1_b, .cmp_out_t1_b_en, .cmp_out_t2_a, .cmp_out_t2_a_en,
    .spi_slave_dout, .spi_master_dout, .spi_sck_out, .spi_master_din, .spi_slave_din,
    .spi_sck_in, .spi_slave_active, .ext_irq_zero, .capture_in_t1, .seg_link);
  pbo_pad_model pbo_pad_model_b_inst (.clk, .pad_o(pad_b_o), .pad_oe(pad_b_oe),
    .pad_pullup(pad_b_pullup), .ext_val(xv_b), .ext_drv(xd_b), .pad_in(pad_b_in));
  pbo_pad_model pbo_pad_model_c_inst (.clk, .pad_o(pad_c_o), .pad_oe(pad_c_oe),
    .pad_pullup(pad_c_pullup), .ext_val(xv_c), .ext_drv(xd_c), .pad_in(pad_c_in));
  pbo_pad_model pbo_pad_model_d_inst (.clk, .pad_o(pad_d_o), .pad_oe(pad_d_oe),
    .pad_pullup(pad_d_pullup), .ext_val(xv_d), .ext_drv(xd_d), .pad_in(pad_d_in));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // pad feedback needs one edge to register, one more to reach the gated level
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask : settle
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic t_plain;
    dir_reg_b = 8'hF0; out_reg_b = 8'h5A; xd_b = 8'h0F; xv_b = 8'h03;
    pin_change_group1_en = 1'b1; pin_change_mask1 = 8'hFF;
    settle;
    chk("b oe", pad_b_oe, 8'hF0);
    chk("b o", pad_b_o & 8'hF0, 8'h50);
    chk("b pullup", pad_b_pullup, 8'h0A);
    chk("pc src", pin_change_src, 8'h53);
    chk("b lvl", pin_lvl_b, 8'h53);
    global_pullup_off = 1'b1;
    settle;
    chk("b pullup off", pad_b_pullup, 8'h00);
    $display("test plain done");
  endtask : t_plain
  task automatic t_slave;
    global_pullup_off = 1'b0; serial_periph_on = 1'b1; master_select = 1'b0;
    dir_reg_b = 8'h0F; out_reg_b = 8'h07; spi_slave_dout = 1'b1; xd_b = 8'h07; xv_b = 8'h04;
    settle;
    chk("slave oe", pad_b_oe & 8'h0F, 8'h08);
    chk("slave o3", pad_b_o[3], 1'b1);
    chk("slave pu", pad_b_pullup & 8'h0F, 8'h07);
    chk("slave act", spi_slave_active, 1'b1);
    chk("slave din", spi_slave_din, 1'b1);
    chk("sck in", spi_sck_in, 1'b0);
    xv_b = 8'h03; spi_slave_dout = 1'b0;
    settle;
    chk("slave idle", spi_slave_active, 1'b0);
    chk("slave din lo", spi_slave_din, 1'b0);
    chk("sck in hi", spi_sck_in, 1'b1);
    chk("slave o3 lo", pad_b_o[3], 1'b0);
    $display("test slave done");
  endtask : t_slave
  task automatic t_master;
    master_select = 1'b1; out_reg_b = 8'h0E; spi_master_dout = 1'b1; spi_sck_out = 1'b0;
    xd_b = 8'h08; xv_b = 8'h08;
    settle;
    chk("master oe", pad_b_oe & 8'h0F, 8'h07);
    chk("master o", pad_b_o & 8'h07, 8'h04);
    chk("master pu", pad_b_pullup & 8'h08, 8'h08);
    chk("master din", spi_master_din, 1'b1);
    out_reg_b = 8'h0F; spi_master_dout = 1'b0; spi_sck_out = 1'b1; global_pullup_off = 1'b1;
    settle;
    chk("master o2", pad_b_o & 8'h07, 8'h03);
    chk("master pu off", pad_b_pullup & 8'h08, 8'h00);
    $display("test master done");
  endtask : t_master
  task automatic t_compare;
    serial_periph_on = 1'b0; dir_reg_b = 8'hF0; out_reg_b = 8'hF0; cmp = 4'h0;
    for (int i = 0; i < 4; i++) begin
      cmp_en = 4'h1 << i;
      settle;
      chk("cmp o", pad_b_o & 8'hF0, 8'hF0 ^ (8'h10 << i));
      chk("cmp oe", pad_b_oe & 8'hF0, 8'hF0);
    end
    cmp_en = 4'h0;
    $display("test compare done");
  endtask : t_compare
  task automatic t_display;
    display_ctrl_on = 1'b1; dir_reg_c = 8'hFF; out_reg_c = 8'hFF; dir_reg_d = 8'hFF;
    out_reg_d = 8'hFF; xd_c = 8'hFF; xv_c = 8'hA5; xd_d = 8'hFF; xv_d = 8'h03;
    settle;
    chk("c oe", pad_c_oe, 8'h00);
    chk("c pu", pad_c_pullup, 8'h00);
    chk("c lvl", pin_lvl_c, 8'h00);
    chk("d oe", pad_d_oe, 8'h00);
    chk("c o", pad_c_o, 8'hFF);
    chk("d o", pad_d_o, 8'hFF);
    chk("d pu", pad_d_pullup, 8'h00);
    chk("d lvl", pin_lvl_d, 8'h00);
    chk("seg", seg_link, 18'h3FCFF);
    chk("capture", capture_in_t1, 1'b1);
    ext_irq_zero_en = 1'b1;
    settle;
    chk("seg irq", seg_link, 18'h2FCFF);
    chk("irq0", ext_irq_zero, 1'b1);
    display_ctrl_on = 1'b0;
    settle;
    chk("seg off", seg_link, 18'h00000);
    chk("c oe on", pad_c_oe, 8'hFF);
    chk("c lvl own", pin_lvl_c, 8'hFF);
    $display("test display done");
  endtask : t_display
  initial begin
    nrst = 1'b0; global_pullup_off = 1'b0; serial_periph_on = 1'b0; master_select = 1'b0;
    display_ctrl_on = 1'b0; ext_irq_zero_en = 1'b0; pin_change_group1_en = 1'b0;
    spi_slave_dout = 1'b0; spi_master_dout = 1'b0; spi_sck_out = 1'b0; cmp = 4'h0;
    cmp_en = 4'h0; pin_change_mask1 = 8'h00; out_reg_b = 8'h00; dir_reg_b = 8'h00;
    out_reg_c = 8'h00; dir_reg_c = 8'h00; out_reg_d = 8'h00; dir_reg_d = 8'h00;
    xv_b = 8'h00; xd_b = 8'h00; xv_c = 8'h00; xd_c = 8'h00; xv_d = 8'h00; xd_d = 8'h00;
    repeat (20) @(negedge clk);
    chk("rst oe", pad_b_oe, 8'h00);
    chk("rst seg", seg_link, 18'h00000);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_plain;
    t_slave;
    t_master;
    t_compare;
    t_display;
    close_out;
  end
  // tests take about 50 cycles; allow generous slack
  initial begin
    #40000;
    n_mismatch++;
    close_out;
  end
endmodule : tb_pbo_top
